// ===== verilog/irq_ctrl_pkg.sv
// Package: register map, field positions and types for the six-source interrupt controller
package irq_ctrl_pkg;
   localparam int unsigned NUM_SRC    = 6;
   localparam int unsigned NUM_LEVELS = 4;
   localparam int unsigned ADDR_W     = 4;
   localparam int unsigned DATA_W     = 32;

   // Word-aligned byte addresses
   localparam logic [ADDR_W-1:0] ENABLE_ADDR   = 4'h0;
   localparam logic [ADDR_W-1:0] PRIO_LO_ADDR  = 4'h4;
   localparam logic [ADDR_W-1:0] PRIO_HI_ADDR  = 4'h8;
   localparam logic [ADDR_W-1:0] STATUS_ADDR   = 4'hC;

   localparam int unsigned GLOBAL_EN_BIT = 7;
   localparam int unsigned SRC_FIELD_W   = 6;

   // Source index equals bit position and polling rank
   localparam int unsigned SRC_EXT0   = 0;
   localparam int unsigned SRC_TIMER0 = 1;
   localparam int unsigned SRC_EXT1   = 2;
   localparam int unsigned SRC_TIMER1 = 3;
   localparam int unsigned SRC_SERIAL = 4;
   localparam int unsigned SRC_TIMER2 = 5;

   localparam logic [7:0] ENABLE_RESET  = 8'h00;
   localparam logic [7:0] PRIO_RESET    = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

   // Status word layout
   localparam int unsigned ST_PEND_LSB   = 0;
   localparam int unsigned ST_ACTIVE_LSB = 8;
   localparam int unsigned ST_REQ_BIT    = 16;
   localparam int unsigned ST_VEC_LSB    = 20;

   typedef logic [1:0] level_t;
   localparam level_t LEVEL_TOP = 2'h3;
endpackage

// ===== verilog/irq_select.sv
// Level and polling-order arbiter across the six sources
`timescale 1ns/1ps
module irq_select #(
   parameter int unsigned N = 6
) (
   input  wire logic [N-1:0]   req,
   input  wire logic [N-1:0]   prio_lo,
   input  wire logic [N-1:0]   prio_hi,
   output logic                found,
   output logic [2:0]          winner,
   output logic [1:0]          win_level
);
   import irq_ctrl_pkg::*;

   // Checked while elaborating: the polling order and vector width fit six sources only
   if (N != NUM_SRC || N > 8) begin : g_bad_n
      $error("irq_select supports exactly six sources");
   end

   always_comb begin
      found     = 1'b0;
      winner    = 3'h0;
      win_level = 2'h0;
      // Scan low index first; a later source wins only with a strictly higher level
      for (int i = 0; i < N; i++) begin
         if (req[i] && (!found || {prio_hi[i], prio_lo[i]} > win_level)) begin
            found     = 1'b1;
            winner    = 3'(i);
            win_level = {prio_hi[i], prio_lo[i]};
         end
      end
   end
endmodule // irq_select

// ===== verilog/irq_ctrl.sv
// Six-source, four-level interrupt controller with Avalon-MM register slave
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module irq_ctrl (
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   // Avalon-MM slave
   input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]   avs_address,
   input  wire logic                              avs_read,
   input  wire logic                              avs_write,
   input  wire logic [irq_ctrl_pkg::DATA_W-1:0]   avs_writedata,
   input  wire logic [3:0]                        avs_byteenable,
   output logic      [irq_ctrl_pkg::DATA_W-1:0]   avs_readdata,
   output logic                                   avs_waitrequest,
   // Request sources
   input  wire logic                              ext_request_pin0,
   input  wire logic                              ext_request_pin1,
   input  wire logic                              timer0_ovf,
   input  wire logic                              timer1_ovf,
   input  wire logic                              timer2_ovf,
   input  wire logic                              serial_irq,
   // Core side
   output logic                                   irq_req,
   output logic      [2:0]                        irq_vector,
   input  wire logic                              irq_ack,
   input  wire logic                              irq_return
);
   import irq_ctrl_pkg::*;

   localparam int unsigned SYNC_N = 3;

   logic [7:0]        enable_mask;
   logic [7:0]        prio_lo_reg;
   logic [7:0]        prio_hi_reg;
   logic [NUM_SRC-1:0] raw_req;
   logic [NUM_SRC-1:0] src_req;
   logic [NUM_SRC-1:0] gated_req;
   logic [NUM_SRC-1:0] pin_raw;
   logic [SYNC_N-1:0] pin_sync [2];
   logic [1:0]        pin_level;
   logic [NUM_LEVELS-1:0] active;
   logic              found;
   logic [2:0]        winner;
   logic [1:0]        win_level;
   logic              next_irq_req;
   logic              access_done;
   logic              wr_en;
   logic              cur_any;
   logic [1:0]        cur_level;

   // Pins are active low and asynchronous; three-stage chain, change accepted on agreement
   assign pin_raw = {4'h0, ~ext_request_pin1, ~ext_request_pin0};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               pin_sync[g]  <= '0;
               pin_level[g] <= 1'b0;
            end else begin
               pin_sync[g] <= {pin_sync[g][SYNC_N-2:0], pin_raw[g]};
               if (pin_sync[g][1] == pin_sync[g][2]) begin
                  pin_level[g] <= pin_sync[g][2];
               end
            end
         end
      end
   endgenerate

   // Six sources, index equals vector and polling rank
   assign raw_req = {timer2_ovf, serial_irq, timer1_ovf,
                     pin_level[1], timer0_ovf, pin_level[0]};
   assign src_req = raw_req;

   // Gating by the per-source and global enables
   assign gated_req = src_req & enable_mask[SRC_FIELD_W-1:0]
                      & {NUM_SRC{enable_mask[GLOBAL_EN_BIT]}};

   irq_select #(
      .N         (NUM_SRC)
   ) u_select (
      .req       (gated_req),
      .prio_lo   (prio_lo_reg[SRC_FIELD_W-1:0]),
      .prio_hi   (prio_hi_reg[SRC_FIELD_W-1:0]),
      .found     (found),
      .winner    (winner),
      .win_level (win_level)
   );

   // Highest level now in service
   always_comb begin
      cur_any   = 1'b0;
      cur_level = 2'h0;
      for (int l = 0; l < NUM_LEVELS; l++) begin
         if (active[l]) begin
            cur_any   = 1'b1;
            cur_level = 2'(l);
         end
      end
   end

   // Preempt only with a strictly higher level; level 3 in service blocks all
   always_comb begin
      next_irq_req = 1'b0;
      if (found && !(irq_req && irq_ack)) begin
         if (!cur_any) begin
            next_irq_req = 1'b1;
         end else if (cur_level != LEVEL_TOP && win_level > cur_level) begin
            next_irq_req = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_req    <= 1'b0;
         irq_vector <= 3'h0;
      end else begin
         irq_req <= next_irq_req;
         if (next_irq_req) begin
            irq_vector <= winner;
         end
      end
   end

   // In-service levels: set on acknowledge, highest cleared on return
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         active <= '0;
      end else begin
         if (irq_return && cur_any) begin
            active[cur_level] <= 1'b0;
         end
         if (irq_req && irq_ack) begin
            active[{prio_hi_reg[irq_vector], prio_lo_reg[irq_vector]}] <= 1'b1;
         end
      end
   end

   // Avalon-MM: one wait cycle, then answer
   assign wr_en = avs_write && access_done && avs_byteenable[0];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         access_done     <= 1'b0;
      end else begin
         access_done     <= (avs_read || avs_write) && !access_done;
         avs_waitrequest <= !((avs_read || avs_write) && !access_done);
      end
   end

   // Reserved bits are not stored and read as zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         enable_mask <= ENABLE_RESET;
         prio_lo_reg <= PRIO_RESET;
         prio_hi_reg <= PRIO_RESET;
      end else if (wr_en) begin
         case (avs_address)
            ENABLE_ADDR: begin
               enable_mask <= {avs_writedata[GLOBAL_EN_BIT], 1'b0,
                               avs_writedata[SRC_FIELD_W-1:0]};
            end
            PRIO_LO_ADDR: begin
               prio_lo_reg <= {2'h0, avs_writedata[SRC_FIELD_W-1:0]};
            end
            PRIO_HI_ADDR: begin
               prio_hi_reg <= {2'h0, avs_writedata[SRC_FIELD_W-1:0]};
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= UNMAPPED_READ;
      end else if (avs_read && !access_done) begin
         case (avs_address)
            ENABLE_ADDR:  avs_readdata <= {24'h00_0000, enable_mask};
            PRIO_LO_ADDR: avs_readdata <= {24'h00_0000, prio_lo_reg};
            PRIO_HI_ADDR: avs_readdata <= {24'h00_0000, prio_hi_reg};
            STATUS_ADDR: begin
               avs_readdata <= UNMAPPED_READ;
               avs_readdata[ST_PEND_LSB +: NUM_SRC]      <= src_req;
               avs_readdata[ST_ACTIVE_LSB +: NUM_LEVELS] <= active;
               avs_readdata[ST_REQ_BIT]                  <= irq_req;
               avs_readdata[ST_VEC_LSB +: 3]             <= irq_vector;
            end
            default:      avs_readdata <= UNMAPPED_READ;
         endcase
      end
   end
endmodule // irq_ctrl

// ===== verif/irq_ctrl_properties.sv
// Port checker for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_properties (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        irq_req,
   input wire logic [2:0]  irq_vector,
   input wire logic        irq_ack
);
   import irq_ctrl_pkg::*;
   logic [7:0] en_sh;
   logic [7:0] en_d;
   logic       rd_ok;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   assign rd_ok = avs_read && !avs_waitrequest;
   // Shadow enable register: gating is judged from the bus traffic alone
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         en_sh <= ENABLE_RESET;
         en_d <= ENABLE_RESET;
      end else begin
         if (avs_write && !avs_waitrequest && avs_address == ENABLE_ADDR && avs_byteenable[0]) begin
            en_sh <= avs_writedata[7:0];
         end
         en_d <= en_sh;
      end
   end
   property p_wait_ans; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("answer too long");
   property p_rsv_en; rd_ok && avs_address == ENABLE_ADDR |-> !avs_readdata[6]; endproperty
   a_rsv_en: assert property (p_rsv_en) else $error("enable bit 6 set");
   property p_rsv_pri;
      rd_ok && (avs_address == PRIO_LO_ADDR || avs_address == PRIO_HI_ADDR)
         |-> avs_readdata[7:6] == 2'h0;
   endproperty
   a_rsv_pri: assert property (p_rsv_pri) else $error("priority bits 7:6 set");
   property p_gate; irq_req |-> en_d[irq_vector]; endproperty
   a_gate: assert property (p_gate) else $error("disabled source sent");
   property p_global; (!en_sh[GLOBAL_EN_BIT])[*2] |-> !irq_req; endproperty
   a_global: assert property (p_global) else $error("global off ignored");
   property p_vec; irq_req |-> irq_vector <= 3'h5; endproperty
   a_vec: assert property (p_vec) else $error("vector out of range");
   property p_ack; irq_req && irq_ack |=> !irq_req; endproperty
   a_ack: assert property (p_ack) else $error("request after ack");
   cover property (irq_req && irq_ack && irq_vector == 3'h5);
   cover property (avs_write && !avs_waitrequest);
   cover property ($fell(irq_req));
endmodule // irq_ctrl_properties
bind irq_ctrl irq_ctrl_properties irq_ctrl_properties_i (.clk, .rst_n, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .irq_req, .irq_vector, .irq_ack);

// ===== verif/irq_core_model.sv
// Behavioural core: takes vectors and returns from service
`timescale 1ns/1ps
module irq_core_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       irq_req,
   input  wire logic [2:0] irq_vector,
   input  wire logic       slow,
   input  wire logic       ret_cmd,
   output logic            irq_ack,
   output logic            irq_return,
   output logic [2:0]      taken,
   output int              acks
);
   logic [1:0] wait_cnt;
   // Slow mode lets the request stand before the vector is taken
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_ack <= 1'b0;
         irq_return <= 1'b0;
         taken <= 3'h0;
         acks <= 0;
         wait_cnt <= 2'h0;
      end else begin
         irq_return <= ret_cmd;
         irq_ack <= 1'b0;
         if (irq_ack && irq_req) begin
            taken <= irq_vector;
            acks <= acks + 1;
         end else if (irq_req && (!slow || wait_cnt == 2'h3)) begin
            irq_ack <= 1'b1;
            wait_cnt <= 2'h0;
         end else if (irq_req) begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule // irq_core_model

// ===== verif/six_source_four_level_irq_ctrl_tb.sv
// Testbench for the interrupt controller
`timescale 1ns/1ps
module six_source_four_level_irq_ctrl_tb;
   import irq_ctrl_pkg::*;
   logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic        irq_req, irq_ack, irq_return, slow, ret_cmd;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [5:0]  src;
   logic [2:0]  irq_vector, taken;
   int          acks, err_count, cmp_count, cyc, served;
   irq_ctrl irq_ctrl_i (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .ext_request_pin0(~src[0]),
      .timer0_ovf(src[1]), .ext_request_pin1(~src[2]), .timer1_ovf(src[3]),
      .serial_irq(src[4]), .timer2_ovf(src[5]), .irq_req, .irq_vector, .irq_ack, .irq_return);
   irq_core_model irq_core_model_i (.clk, .rst_n, .irq_req, .irq_vector, .slow, .ret_cmd,
      .irq_ack, .irq_return, .taken, .acks);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   task report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Request is held until the edge that sees waitrequest low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk("readdata", e, q);
   endtask
   task quiet();
      repeat (10) @(posedge clk);
      chk("irq_req", 32'h0000_0000, {31'h0000_0000, irq_req});
   endtask
   task ret();
      @(posedge clk);
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
   endtask
   // Pin requests pass a synchronizer, so wait before ending service
   task serve(input logic [2:0] v, input logic r);
      // An acknowledge may land while a bus call is still running, so count them all
      while (acks <= served) @(posedge clk);
      served++;
      chk("vector", {29'h0000_0000, v}, {29'h0000_0000, taken});
      src[v] <= 1'b0;
      repeat (6) @(posedge clk);
      if (r) ret();
   endtask
   initial begin
      {rst_n, avs_read, avs_write, slow, ret_cmd} = 5'h00;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      src = 6'h00;
      {err_count, cmp_count, cyc} = {32'h0, 32'h0, 32'h0};
      served = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(PRIO_LO_ADDR, 32'h0000_0000);
      rd(4'h6, 32'h0000_0000);
      bus(1'b1, ENABLE_ADDR, 32'h0000_003F);
      src <= 6'h3F;
      quiet();
      rd(STATUS_ADDR, 32'h0000_003F);
      bus(1'b1, ENABLE_ADDR, 32'h0000_0080);
      quiet();
      bus(1'b1, ENABLE_ADDR, 32'h0000_00BF);
      rd(ENABLE_ADDR, 32'h0000_00BF);
      for (int i = 0; i < 6; i++) serve(i[2:0], 1'b1);
      bus(1'b1, PRIO_LO_ADDR, 32'h0000_0028);
      bus(1'b1, PRIO_HI_ADDR, 32'h0000_0030);
      rd(PRIO_HI_ADDR, 32'h0000_0030);
      slow <= 1'b1;
      src <= 6'h3F;
      serve(3'h5, 1'b0);
      quiet();
      ret();
      serve(3'h4, 1'b1);
      serve(3'h3, 1'b1);
      for (int i = 0; i < 3; i++) serve(i[2:0], 1'b1);
      bus(1'b1, PRIO_HI_ADDR, 32'h0000_0000);
      bus(1'b1, PRIO_LO_ADDR, 32'h0000_0008);
      slow <= 1'b0;
      src <= 6'h01;
      serve(3'h0, 1'b0);
      src[1] <= 1'b1;
      quiet();
      src[3] <= 1'b1;
      serve(3'h3, 1'b1);
      quiet();
      ret();
      serve(3'h1, 1'b1);
      report_and_stop();
   end
endmodule // six_source_four_level_irq_ctrl_tb
